// ### core/spi_host_pkg.sv
package spi_host_pkg;
  localparam int AXI_AW = 8;
  localparam int NUM_SS = 4;
  localparam int SS_W = 2;
  localparam int BYTE_W = 8;
  localparam int DIV_W = 8;
  localparam logic [3:0] LAST_EDGE = 4'hf;

  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_TX = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_RX = 8'h0c;

  localparam int CTRL_EN = 0;
  localparam int CTRL_IDLE_LVL = 1;
  localparam int CTRL_CKE = 2;
  localparam int CTRL_SMP_END = 3;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_HOLD = 6;
  localparam int CTRL_DIV_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0100;

  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_COLL = 2;
  localparam int STAT_MISO = 3;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_TRAIL = 4'b1000
  } xfer_state_e;
endpackage : spi_host_pkg

// ### core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,   // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pin,   // Asynchronous pin level
  output logic level      // Synchronised level
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s cur;
  sync_s next_cur;

  always_comb begin
    next_cur.meta = pin;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.stable;
endmodule : pin_sync

// ### core/sck_divider.sv
`timescale 1ns/1ps
module sck_divider (
  input wire logic clk,                         // System clock
  input wire logic rst_n,                       // Async reset, active low
  input wire logic run,                         // Count while high
  input wire logic [spi_host_pkg::DIV_W-1:0] div, // Half period minus one
  output logic tick                             // One-cycle half-period pulse
);
  import spi_host_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } div_s;

  div_s cur;
  div_s next_cur;

  always_comb begin
    next_cur = cur;
    if (!run) begin
      next_cur.cnt = '0;
      next_cur.tick = 1'b0;
    end else if (cur.cnt == div) begin
      next_cur.cnt = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 8'h01;
      next_cur.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule : sck_divider

// ### core/spi_host_top.sv
// Behaviour
// R01 - Device uses one 8-bit shift register
// R02 - Bytes travel MSb first, enter at LSb
// R03 - Launch on one edge, capture opposite
// R04 - Master alone generates the serial clock
// R05 - Eight clock periods swap both bytes
// R06 - Unselected slave ignores clock, drives nothing
// R07 - At most one slave select asserted
// R08 - Idle master stops clock, deselects slave; with HOLD (bit 6) set the select stays low
// R09 - Both ends share idle clock level
// R10 - Full byte copied to buffer, flag raised
// R11 - Buffer write loads shift register directly
// R12 - Options live in two control fields
// R13 - Mode, polarity, edge, sample, rate, select
// R14 - Enable hands pins over; disable to reconfigure
// R15 - Data in input, data out output
// R16 - Buffer-full flag; next byte may start
// R17 - Write during shifting dropped, collision set
// R18 - Writes resume after collision flag cleared
// R19 - Reading data buffer clears buffer-full
// R20 - Read received byte before next write
// R21 - Status low six read-only, top two writable; here a write of one to COLL (bit 2) clears the collision flag
// R22 - Address register reloads baud generator
// R23 - Master exchange starts on buffer write
// R24 - Clock rate from divided system clock
// R25 - Select high floats slave data out
// R26 - Module reset clears bit counter
// R27 - Slave synchronises clock and select first
`timescale 1ns/1ps
module spi_host_top (
  input wire logic clk,                                // System clock, 50 MHz
  input wire logic rst_n,                              // Async reset, active low
  input wire logic [spi_host_pkg::AXI_AW-1:0] awaddr,  // Write address
  input wire logic awvalid,                            // Write address valid
  output logic awready,                                // Write address ready
  input wire logic [31:0] wdata,                       // Write data
  input wire logic [3:0] wstrb,                        // Write byte strobes
  input wire logic wvalid,                             // Write data valid
  output logic wready,                                 // Write data ready
  output logic [1:0] bresp,                            // Write response
  output logic bvalid,                                 // Write response valid
  input wire logic bready,                             // Write response ready
  input wire logic [spi_host_pkg::AXI_AW-1:0] araddr,  // Read address
  input wire logic arvalid,                            // Read address valid
  output logic arready,                                // Read address ready
  output logic [31:0] rdata,                           // Read data
  output logic [1:0] rresp,                            // Read response
  output logic rvalid,                                 // Read data valid
  input wire logic rready,                             // Read data ready
  output logic spi_sck,                                // Serial clock to device
  output logic spi_mosi,                               // Data to device data-in
  input wire logic spi_miso,                           // Data from device data-out
  output logic [spi_host_pkg::NUM_SS-1:0] spi_ss_n     // Slave selects, active low
);
  import spi_host_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl;
    xfer_state_e st;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] rx;
    logic [BYTE_W-1:0] rx_data;
    logic [3:0] edge_cnt;
    logic full;
    logic coll;
    logic pend;
    logic sck;
    logic mosi;
    logic [NUM_SS-1:0] ss_n;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_s;

  host_s cur;
  host_s next_cur;
  logic miso_s;
  logic tick;
  logic run;

  pin_sync u_miso_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(spi_miso),
    .level(miso_s)
  );

  assign run = (cur.st != ST_IDLE);

  sck_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .div(cur.ctrl[CTRL_DIV_LSB +: DIV_W]), // see R24
    .tick(tick)
  );

  logic en;
  logic idle_lvl;
  logic cke;
  logic smp_end;
  logic hold;
  logic [SS_W-1:0] sel;
  assign en = cur.ctrl[CTRL_EN];
  assign idle_lvl = cur.ctrl[CTRL_IDLE_LVL];
  assign cke = cur.ctrl[CTRL_CKE];
  assign smp_end = cur.ctrl[CTRL_SMP_END];
  assign hold = cur.ctrl[CTRL_HOLD];
  assign sel = cur.ctrl[CTRL_SEL_LSB +: SS_W];

  always_comb begin
    logic do_wr;
    logic wr_ok;
    logic ar_hs;
    logic capture;
    logic [BYTE_W-1:0] rx_fin;
    logic [31:0] rd;
    logic [1:0] rr;
    do_wr = 1'b0;
    wr_ok = 1'b0;
    ar_hs = 1'b0;
    capture = 1'b0;
    rx_fin = '0;
    rd = '0;
    rr = RESP_OKAY;
    next_cur = cur;

    // Write channels accepted independently, in either order
    if (awvalid && cur.awready) begin
      next_cur.awready = 1'b0;
      next_cur.aw_got = 1'b1;
      next_cur.awaddr = awaddr;
    end
    if (wvalid && cur.wready) begin
      next_cur.wready = 1'b0;
      next_cur.w_got = 1'b1;
      next_cur.wdata = wdata;
      next_cur.wstrb = wstrb;
    end
    do_wr = cur.aw_got && cur.w_got && !cur.bvalid;
    if (bvalid && bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end

    // Clock idles at the programmed level; follows reconfiguration
    if (cur.st == ST_IDLE) begin
      next_cur.sck = idle_lvl; // see R09
      next_cur.edge_cnt = '0;
      next_cur.pend = 1'b0;
      if (!hold) begin
        next_cur.ss_n = '1; // see R08
      end
    end

    // Byte engine
    case (cur.st)
      ST_IDLE: begin
      end
      ST_LEAD: begin
        if (tick) begin
          next_cur.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          next_cur.sck = ~cur.sck; // see R04
          capture = (cur.edge_cnt[0] != cke); // see R03
          if (capture) begin
            if (smp_end) begin
              next_cur.pend = 1'b1;
            end else begin
              next_cur.rx = {cur.rx[BYTE_W-2:0], miso_s}; // see R02
            end
          end else begin
            if (cur.pend) begin
              next_cur.rx = {cur.rx[BYTE_W-2:0], miso_s};
              next_cur.pend = 1'b0;
            end
            next_cur.mosi = cke ? cur.tx[BYTE_W-2] : cur.tx[BYTE_W-1]; // see R02
            next_cur.tx = {cur.tx[BYTE_W-2:0], 1'b0};
          end
          next_cur.edge_cnt = cur.edge_cnt + 4'h1;
          if (cur.edge_cnt == LAST_EDGE) begin
            next_cur.st = ST_TRAIL; // see R05
          end
        end
      end
      ST_TRAIL: begin
        if (tick) begin
          rx_fin = cur.pend ? {cur.rx[BYTE_W-2:0], miso_s} : cur.rx;
          next_cur.rx = rx_fin;
          next_cur.pend = 1'b0;
          next_cur.rx_data = rx_fin; // see R05
          next_cur.full = 1'b1; // see R16
          next_cur.st = ST_IDLE;
          next_cur.sck = idle_lvl;
          if (!hold) begin
            next_cur.ss_n = '1; // see R08
          end
        end
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase

    // Register writes; these follow the byte engine and outrank it
    if (do_wr) begin
      next_cur.bvalid = 1'b1;
      wr_ok = 1'b1;
      case (cur.awaddr)
        OFS_CTRL: begin
          if (cur.wstrb[0]) begin
            next_cur.ctrl[7:0] = cur.wdata[7:0];
          end
          if (cur.wstrb[1]) begin
            next_cur.ctrl[15:8] = cur.wdata[15:8];
          end
        end
        OFS_STATUS: begin
          if (cur.wstrb[0] && cur.wdata[STAT_COLL]) begin
            next_cur.coll = 1'b0; // see R18
          end
        end
        OFS_TX: begin
          if (cur.wstrb[0] && en) begin
            if (cur.st != ST_IDLE) begin
              next_cur.coll = 1'b1; // see R17
            end else if (!cur.coll) begin // see R18
              next_cur.tx = cur.wdata[BYTE_W-1:0];
              next_cur.rx = '0;
              next_cur.edge_cnt = '0; // see R26
              next_cur.st = ST_LEAD; // see R23
              next_cur.ss_n = ~(4'h1 << sel); // see R07
              if (cke) begin
                next_cur.mosi = cur.wdata[BYTE_W-1];
              end
            end
          end
        end
        OFS_RX: begin
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      next_cur.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Reads; buffer read clears full unless a byte lands this cycle
    ar_hs = arvalid && cur.arready;
    if (ar_hs) begin
      case (araddr)
        OFS_CTRL: begin
          rd = {16'h0000, cur.ctrl};
        end
        OFS_STATUS: begin
          rd[STAT_BUSY] = (cur.st != ST_IDLE);
          rd[STAT_FULL] = cur.full;
          rd[STAT_COLL] = cur.coll;
          rd[STAT_MISO] = miso_s;
        end
        OFS_TX: begin
        end
        OFS_RX: begin
          rd = {24'h000000, cur.rx_data};
          if (!(cur.st == ST_TRAIL && tick)) begin
            next_cur.full = 1'b0; // see R19
          end
        end
        default: begin
          rr = RESP_SLVERR;
        end
      endcase
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rdata = rd;
      next_cur.rresp = rr;
    end
    if (cur.rvalid && rready) begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end

    // Disable aborts and releases the link
    if (!next_cur.ctrl[CTRL_EN]) begin
      next_cur.st = ST_IDLE; // see R14
      next_cur.ss_n = '1; // see R06
      next_cur.sck = next_cur.ctrl[CTRL_IDLE_LVL];
      next_cur.edge_cnt = '0;
      next_cur.pend = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.ctrl <= CTRL_RESET;
      cur.st <= ST_IDLE;
      cur.ss_n <= '1;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // All outputs are plain flops; data out and clock always driven
  assign awready = cur.awready;
  assign wready = cur.wready;
  assign bresp = cur.bresp;
  assign bvalid = cur.bvalid;
  assign arready = cur.arready;
  assign rdata = cur.rdata;
  assign rresp = cur.rresp;
  assign rvalid = cur.rvalid;
  assign spi_sck = cur.sck; // see R15
  assign spi_mosi = cur.mosi; // see R15
  assign spi_ss_n = cur.ss_n;
endmodule : spi_host_top

// ### verification/spi_host_props.sv
`timescale 1ns/1ps
module spi_host_props (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic awvalid, // AW valid
  input wire logic awready, // AW ready
  input wire logic wvalid, // W valid
  input wire logic wready, // W ready
  input wire logic bvalid, // B valid
  input wire logic bready, // B ready
  input wire logic arvalid, // AR valid
  input wire logic arready, // AR ready
  input wire logic rvalid, // R valid
  input wire logic rready, // R ready
  input wire logic spi_sck, // Serial clock
  input wire logic [spi_host_pkg::NUM_SS-1:0] spi_ss_n // Selects
);
  logic idle;
  logic sck_d;
  logic [4:0] edges;
  assign idle = &spi_ss_n;
  // Serial clock edges seen within one selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      edges <= 5'h00;
    end else begin
      sck_d <= spi_sck;
      if (idle) edges <= 5'h00;
      else if (spi_sck != sck_d) edges <= edges + 5'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sel_onehot_a: assert property ($onehot0(~spi_ss_n))
    else $error("two selects low");
  // A config write may move the idle level, nothing else may
  sck_quiet_a: assert property ($changed(spi_sck) && idle |-> bvalid || $past(bvalid))
    else $error("clock moved while deselected");
  half_period_a: assert property ($changed(spi_sck) && !idle |=>
    (!$changed(spi_sck) || idle) [*3])
    else $error("half period too short");
  byte_edges_a: assert property ($rose(idle) && !bvalid && !$past(bvalid) |-> edges == 5'h10)
    else $error("byte without 16 edges");
  wr_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("late write response");
  rd_latency_a: assert property (arvalid && arready |=> rvalid)
    else $error("late read data");
  b_single_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  r_single_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
endmodule : spi_host_props

// ### verification/spi_dev_model.sv
`timescale 1ns/1ps
module spi_dev_model (
  input wire logic ss_n, // Select, active low
  input wire logic sck, // Serial clock, never driven here
  input wire logic mosi, // Data in
  input wire logic cke, // Launch before first edge
  input wire logic idle_lvl, // Agreed idle level
  input wire logic [7:0] reply, // Byte sent back
  output logic miso, // Data out
  output logic [7:0] got, // Last byte in
  output logic [7:0] count, // Bytes done
  output logic idle_err // Clock not idle at select
);
  logic [7:0] sr;
  int edges;
  int bits;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    count = 8'h00;
    idle_err = 1'b0;
  end
  always @(negedge ss_n) begin
    sr = reply;
    edges = 0;
    bits = 0;
    if (sck !== idle_lvl) idle_err = 1'b1;
    if (cke) miso = sr[7];
  end
  // Released line floats; the inverse keeps a stale bit from matching
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n) begin
      edges = edges + 1;
      if (edges[0] == cke) begin
        sr = {sr[6:0], mosi};
        bits = bits + 1;
        // Select held across bytes: every eighth bit closes a byte
        if (bits % 8 == 0) begin
          got = sr;
          count = count + 8'h01;
        end
      end else miso = sr[7];
    end
  end
endmodule : spi_dev_model

// ### verification/tb_spi_host_top.sv
`timescale 1ns/1ps
module tb_spi_host_top;
  import spi_host_pkg::*;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, spi_sck, spi_mosi, spi_miso;
  logic cke, idle_lvl, idle_err;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NUM_SS-1:0] spi_ss_n;
  logic [SS_W-1:0] sel;
  logic [7:0] reply, got, count;
  int bad_count;
  int checks_done;
  spi_host_top uut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_ss_n(spi_ss_n));
  spi_dev_model dev (.ss_n(spi_ss_n[sel]), .sck(spi_sck), .mosi(spi_mosi), .cke(cke),
    .idle_lvl(idle_lvl), .reply(reply), .miso(spi_miso), .got(got), .count(count),
    .idle_err(idle_err));
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h not %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tz;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tz = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tz) begin
        bready <= 1'b0;
        return;
      end
    end
    bad_count++;
    stop_test();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tz;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tz = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tz) begin
        rready <= 1'b0;
        return;
      end
    end
    bad_count++;
    stop_test();
  endtask : rd
  task automatic wait_idle;
    logic [31:0] s;
    logic [1:0] r;
    for (int n = 0; n < 60; n++) begin
      rd(OFS_STATUS, s, r);
      if (s[STAT_BUSY] === 1'b0) return;
    end
    bad_count++;
    stop_test();
  endtask : wait_idle
  // Divider 3 keeps four clocks per half period, above the input sync delay
  function automatic logic [31:0] ctl(logic en, logic p, logic e, logic s, logic [1:0] k);
    return {16'h0000, 8'h03, 2'b00, k, s, e, p, en};
  endfunction : ctl
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_CTRL, d, r);
    chk(d, {16'h0000, CTRL_RESET});
    rd(OFS_STATUS, d, r);
    chk(d & 32'h7, 32'h0);
    rd(8'h10, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h10, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : t_regs
  task automatic t_byte(input logic p, e, s, input logic [1:0] k, input logic [7:0] tx, rx);
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c0;
    wr(OFS_CTRL, ctl(1'b0, p, e, s, k), r);
    wr(OFS_CTRL, ctl(1'b1, p, e, s, k), r);
    rd(OFS_CTRL, d, r);
    chk(d, ctl(1'b1, p, e, s, k));
    sel = k;
    cke = e;
    idle_lvl = p;
    reply = rx;
    c0 = count;
    chk({31'h0, spi_sck}, {31'h0, p});
    wr(OFS_TX, {24'h0, tx}, r);
    @(negedge clk);
    chk({28'h0, spi_ss_n}, {28'h0, ~(4'h1 << k)});
    wait_idle();
    rd(OFS_STATUS, d, r);
    chk({31'h0, d[STAT_FULL]}, 32'h1);
    rd(OFS_RX, d, r);
    chk(d, {24'h0, rx});
    chk({24'h0, got}, {24'h0, tx});
    chk({24'h0, count}, {24'h0, c0 + 8'h01});
    rd(OFS_STATUS, d, r);
    chk({31'h0, d[STAT_FULL]}, 32'h0);
  endtask : t_byte
  task automatic t_coll;
    logic [31:0] d;
    logic [1:0] r;
    reply = 8'h66;
    wr(OFS_TX, 32'h11, r);
    wr(OFS_TX, 32'h22, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFS_STATUS, d, r);
    chk(d & 32'h5, 32'h5);
    wait_idle();
    chk({24'h0, got}, 32'h11);
    wr(OFS_TX, 32'h33, r);
    rd(OFS_STATUS, d, r);
    chk(d & 32'h7, 32'h6);
    wr(OFS_STATUS, 32'h4, r);
    reply = 8'h99;
    wr(OFS_TX, 32'h44, r);
    rd(OFS_STATUS, d, r);
    chk(d & 32'h7, 32'h3);
    wait_idle();
    rd(OFS_RX, d, r);
    chk(d, 32'h99);
    chk({24'h0, got}, 32'h44);
  endtask : t_coll
  task automatic t_abort;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c0;
    c0 = count;
    wr(OFS_TX, 32'hff, r);
    repeat (30) @(posedge clk);
    wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 2'h2), r);
    @(negedge clk);
    chk({28'h0, spi_ss_n}, 32'hf);
    rd(OFS_STATUS, d, r);
    chk(d & 32'h3, 32'h0);
    chk({31'h0, d[STAT_MISO]}, {31'h0, spi_miso});
    chk({24'h0, count}, {24'h0, c0});
  endtask : t_abort
  // Select held low across two bytes; the second byte echoes the first
  task automatic t_hold;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h1), r);
    wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 2'h1) | (32'h1 << CTRL_HOLD), r);
    reply = 8'h2d;
    wr(OFS_TX, 32'h17, r);
    wait_idle();
    chk({28'h0, spi_ss_n}, 32'hd);
    rd(OFS_RX, d, r);
    chk(d, 32'h2d);
    wr(OFS_TX, 32'h8e, r);
    wait_idle();
    rd(OFS_RX, d, r);
    chk(d, 32'h17);
    chk({24'h0, got}, 32'h8e);
    wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 2'h1), r);
    @(negedge clk);
    chk({28'h0, spi_ss_n}, 32'hf);
  endtask : t_hold
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cke, idle_lvl} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sel = 2'h0;
    reply = 8'h00;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_byte(1'b0, 1'b0, 1'b0, 2'h0, 8'ha5, 8'h3c);
    t_byte(1'b0, 1'b1, 1'b0, 2'h1, 8'hc3, 8'h96);
    t_byte(1'b1, 1'b0, 1'b0, 2'h2, 8'h81, 8'h7e);
    t_byte(1'b1, 1'b1, 1'b0, 2'h3, 8'h5a, 8'he1);
    t_byte(1'b0, 1'b0, 1'b1, 2'h2, 8'hf0, 8'h0f);
    t_coll();
    t_abort();
    t_byte(1'b0, 1'b0, 1'b0, 2'h1, 8'h69, 8'hb4);
    t_hold();
    chk({31'h0, idle_err}, 32'h0);
    stop_test();
  end
endmodule : tb_spi_host_top
bind spi_host_top spi_host_props chk_i (.clk(clk), .rst_n(rst_n), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .spi_sck(spi_sck), .spi_ss_n(spi_ss_n));
